// ===== design/rc_conv_pkg.sv
// package for the rc oscillation converter: register indices, fields, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
package rc_conv_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address = 4*index
  localparam logic [7:0] IDX_SWITCH = 8'h1A;
  localparam logic [7:0] IDX_CONTROL = 8'h22;
  localparam logic [7:0] IDX_MODE = 8'h25;
  localparam logic [7:0] IDX_REF_LOW = 8'h30;
  localparam logic [7:0] IDX_REF_HIGH = 8'h31;
  localparam logic [7:0] IDX_MEAS_LOW = 8'h32;
  localparam logic [7:0] IDX_MEAS_HIGH = 8'h33;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h34;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h35;

  localparam int CTL_SPARE = 3;
  localparam int CTL_RUN = 4;
  localparam int CTL_SEL_LSB = 5;
  localparam int MODE_OVF_SEL = 0;
  localparam int MODE_ENABLE = 1;
  localparam int MODE_USER_LSB = 4;
  localparam int IRQ_FLAG = 4;

  localparam logic [2:0] SEL_SYS = 3'h0;
  localparam logic [2:0] SEL_SYS_DIV4 = 3'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  localparam logic [7:0] RST_CONTROL = 8'h08;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_SWITCH = 8'h10;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  typedef struct packed {
    logic [2:0] ref_sel;
    logic spare;
    logic run;
  } control_s;

  typedef struct packed {
    logic [3:0] user;
    logic enable;
    logic ovf_sel;
  } mode_s;
endpackage

// ===== design/rc_oscillation_converter.sv
// rc oscillation converter: reference counter, pclk-clocked counter of rc edges,
// analog switch select, apb register slave and one level interrupt.
// assumes rc_osc_in is an asynchronous pin and pclk is well above its rate.
//
// Behaviour
// R1: two independent 16-bit up-counters
// R2: reference clock select: sysclk or sysclk/4
// R3: measurement counter counts rc oscillator edges
// R4: mode bit 1 enables converter, maps counters
// R5: mode bit 0 picks overflow interrupt source
// R6: run bit starts both counters together
// R7: overflow sets converter interrupt flag bit 4
// R8: overflow stops counters, clears run bit
// R9: low-byte write only fills shared buffer
// R10: high-byte write loads byte plus buffer
// R11: high-byte read latches low byte into buffer
// R12: low-byte read returns the buffer
// R13: counter bytes blocked while run is set
// R14: control bits 0-2 zero, bit 3 storage
// R15: mode bits 2-3 zero, 4-7 storage
// R16: switch field closes exactly one switch
// R17: field msb opens all, stops oscillator
// R18: software should prefer sysclk reference source
// R19: interrupt flag sticky until software clears
`timescale 1ns/1ps
module rc_oscillation_converter #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rc_osc_in,
  output logic rc_osc_enable,
  output logic [15:0] sensor_channels,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  rc_conv_pkg::control_s control;
  rc_conv_pkg::mode_s mode;
  logic [4:0] switch_channel_select;
  logic [COUNT_WIDTH-1:0] ref_count;
  logic [COUNT_WIDTH-1:0] meas_count;
  logic [7:0] low_buffer;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [1:0] div4;
  logic [2:0] osc_sync;
  logic osc_level;

  logic access;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic addr_ok;
  logic counter_reg;
  logic counters_open;
  logic ref_ovf;
  logic meas_ovf;
  logic ovf_event;
  logic ref_tick;
  logic meas_tick;

  function automatic logic is_counter_idx(input logic [7:0] i);
    is_counter_idx = (i == rc_conv_pkg::IDX_REF_LOW) || (i == rc_conv_pkg::IDX_REF_HIGH) ||
                     (i == rc_conv_pkg::IDX_MEAS_LOW) || (i == rc_conv_pkg::IDX_MEAS_HIGH);
  endfunction

  assign access = psel && penable;
  assign idx = paddr[9:2];
  assign pready = 1'b1;
  assign counter_reg = is_counter_idx(idx);
  // counter bytes exist only in converter mode and are locked while counting
  assign counters_open = mode.enable && !control.run; // [R4] [R13]

  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
      addr_ok = 1'b0;
    end else if (idx == rc_conv_pkg::IDX_SWITCH || idx == rc_conv_pkg::IDX_CONTROL) begin
      addr_ok = 1'b1;
    end else if (idx == rc_conv_pkg::IDX_MODE) begin
      addr_ok = 1'b1;
    end else if (counter_reg) begin
      addr_ok = counters_open; // [R13]
    end else if (idx == rc_conv_pkg::IDX_IRQ_STATUS || idx == rc_conv_pkg::IDX_IRQ_MASK) begin
      addr_ok = 1'b1;
    end
  end

  assign pslverr = access && !addr_ok;
  assign wr = access && pwrite && addr_ok;
  assign rd = access && !pwrite && addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // counting

  // three-stage sync, edge counted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync <= 3'h0;
      osc_level <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], rc_osc_in};
      if (osc_sync[2] == osc_sync[1]) begin
        osc_level <= osc_sync[2];
      end
    end
  end

  assign meas_tick = control.run && osc_sync[2] && osc_sync[1] && !osc_level; // [R3]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div4 <= 2'h0;
    end else if (control.run) begin
      div4 <= div4 + 2'h1;
    end else begin
      div4 <= 2'h0;
    end
  end

  always_comb begin
    ref_tick = 1'b0;
    if (control.run) begin
      if (control.ref_sel == rc_conv_pkg::SEL_SYS) begin
        ref_tick = 1'b1; // [R2]
      end else if (control.ref_sel == rc_conv_pkg::SEL_SYS_DIV4) begin
        ref_tick = (div4 == rc_conv_pkg::DIV4_LAST); // [R2]
      end
    end
  end

  assign ref_ovf = ref_tick && (&ref_count);
  assign meas_ovf = meas_tick && (&meas_count);
  // either overflow ends the run; the source bit only steers the interrupt
  assign ovf_event = mode.ovf_sel ? meas_ovf : ref_ovf; // [R5]

  // high-byte write loads buffer as low byte; counters only move while run is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_count <= rc_conv_pkg::RST_COUNT;
    end else if (wr && idx == rc_conv_pkg::IDX_REF_HIGH) begin
      ref_count <= {pwdata[7:0], low_buffer}; // [R10]
    end else if (ref_tick && !ref_ovf && !meas_ovf) begin
      ref_count <= ref_count + 16'h0001; // [R1] [R6]
    end else if (ref_ovf) begin
      ref_count <= rc_conv_pkg::RST_COUNT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_count <= rc_conv_pkg::RST_COUNT;
    end else if (wr && idx == rc_conv_pkg::IDX_MEAS_HIGH) begin
      meas_count <= {pwdata[7:0], low_buffer}; // [R10]
    end else if (meas_tick && !ref_ovf && !meas_ovf) begin
      meas_count <= meas_count + 16'h0001; // [R1] [R6]
    end else if (meas_ovf) begin
      meas_count <= rc_conv_pkg::RST_COUNT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared low-byte buffer

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_buffer <= 8'h00;
    end else if (wr && (idx == rc_conv_pkg::IDX_REF_LOW || idx == rc_conv_pkg::IDX_MEAS_LOW)) begin
      low_buffer <= pwdata[7:0]; // [R9]
    end else if (rd && idx == rc_conv_pkg::IDX_REF_HIGH) begin
      low_buffer <= ref_count[7:0]; // [R11]
    end else if (rd && idx == rc_conv_pkg::IDX_MEAS_HIGH) begin
      low_buffer <= meas_count[7:0]; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, mode, switch registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // field by field: the struct order does not follow the bit order of the word
      control.ref_sel <= rc_conv_pkg::RST_CONTROL[rc_conv_pkg::CTL_SEL_LSB +: 3];
      control.spare <= rc_conv_pkg::RST_CONTROL[rc_conv_pkg::CTL_SPARE];
      control.run <= rc_conv_pkg::RST_CONTROL[rc_conv_pkg::CTL_RUN];
    end else begin
      if (wr && idx == rc_conv_pkg::IDX_CONTROL) begin
        control.ref_sel <= pwdata[rc_conv_pkg::CTL_SEL_LSB +: 3];
        control.spare <= pwdata[rc_conv_pkg::CTL_SPARE]; // [R14]
        control.run <= pwdata[rc_conv_pkg::CTL_RUN] && mode.enable; // [R4] [R6]
      end
      // overflow wins over a same-cycle write of run
      if (ref_ovf || meas_ovf) begin
        control.run <= 1'b0; // [R8]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= rc_conv_pkg::mode_s'({rc_conv_pkg::RST_MODE[7:4], rc_conv_pkg::RST_MODE[1:0]});
    end else if (wr && idx == rc_conv_pkg::IDX_MODE) begin
      mode.user <= pwdata[rc_conv_pkg::MODE_USER_LSB +: 4]; // [R15]
      mode.enable <= pwdata[rc_conv_pkg::MODE_ENABLE]; // [R4]
      mode.ovf_sel <= pwdata[rc_conv_pkg::MODE_OVF_SEL]; // [R5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_channel_select <= rc_conv_pkg::RST_SWITCH[4:0];
    end else if (wr && idx == rc_conv_pkg::IDX_SWITCH) begin
      switch_channel_select <= pwdata[4:0];
    end
  end

  // one-hot switch drive; msb set opens all and holds the oscillator off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sensor_channels <= 16'h0000;
      rc_osc_enable <= 1'b0;
    end else begin
      if (switch_channel_select[4]) begin
        sensor_channels <= 16'h0000; // [R17]
      end else begin
        sensor_channels <= 16'h0001 << switch_channel_select[3:0]; // [R16]
      end
      rc_osc_enable <= !switch_channel_select[4] && mode.enable; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt: sticky status cleared by read, masked onto irq

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 8'h00;
    end else begin
      if (rd && idx == rc_conv_pkg::IDX_IRQ_STATUS) begin
        irq_status <= 8'h00; // [R19]
      end
      // a same-cycle overflow beats the clearing read
      if (ovf_event) begin
        irq_status[rc_conv_pkg::IRQ_FLAG] <= 1'b1; // [R7]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= rc_conv_pkg::RST_MASK;
    end else if (wr && idx == rc_conv_pkg::IDX_IRQ_MASK) begin
      irq_mask <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (idx == rc_conv_pkg::IDX_SWITCH) begin
        prdata = {27'h0000000, switch_channel_select}; // [R16]
      end else if (idx == rc_conv_pkg::IDX_CONTROL) begin
        prdata = {24'h000000, control.ref_sel, control.run, control.spare, 3'h0}; // [R14]
      end else if (idx == rc_conv_pkg::IDX_MODE) begin
        prdata = {24'h000000, mode.user, 2'h0, mode.enable, mode.ovf_sel}; // [R15]
      end else if (idx == rc_conv_pkg::IDX_REF_HIGH) begin
        prdata = {24'h000000, ref_count[15:8]}; // [R11]
      end else if (idx == rc_conv_pkg::IDX_MEAS_HIGH) begin
        prdata = {24'h000000, meas_count[15:8]}; // [R11]
      end else if (idx == rc_conv_pkg::IDX_REF_LOW || idx == rc_conv_pkg::IDX_MEAS_LOW) begin
        prdata = {24'h000000, low_buffer}; // [R12]
      end else if (idx == rc_conv_pkg::IDX_IRQ_STATUS) begin
        prdata = {24'h000000, irq_status};
      end else if (idx == rc_conv_pkg::IDX_IRQ_MASK) begin
        prdata = {24'h000000, irq_mask};
      end
    end
  end

endmodule

// ===== testbench/rc_osc_model.sv
// far-side rc sensor oscillator feeding the measurement counter
// assumes enable comes from the converter; slow picks one of two rates
`timescale 1ns/1ps
module rc_osc_model (
  input wire logic enable,
  input wire logic slow,
  output logic osc
);
  // stands still at 0 while stopped, like the real oscillator
  always begin
    osc = 1'b0;
    wait (enable);
    while (enable) begin
      #(slow ? 200 : 40) osc = ~osc;
    end
  end
endmodule

// ===== testbench/rc_conv_assertions.sv
// port checker for the converter: switch select, register reads, interrupt
// assumes the package is compiled first; bound to the converter module below
`timescale 1ns/1ps
module rc_conv_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rc_osc_enable,
  input wire logic [15:0] sensor_channels,
  input wire logic irq
);
  localparam logic [11:0] SW = {2'h0, rc_conv_pkg::IDX_SWITCH, 2'h0};
  localparam logic [11:0] CT = {2'h0, rc_conv_pkg::IDX_CONTROL, 2'h0};
  localparam logic [11:0] MD = {2'h0, rc_conv_pkg::IDX_MODE, 2'h0};
  localparam logic [11:0] ST = {2'h0, rc_conv_pkg::IDX_IRQ_STATUS, 2'h0};
  logic acc;
  logic [15:0] want;
  assign acc = psel && penable;
  // last written switch code, decoded here to compare two cycles on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      want <= 16'h0000;
    end else if (acc && pwrite && paddr == SW) begin
      want <= 16'h0001 << pwdata[3:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  a_switch_onehot: assert property ($onehot0(sensor_channels))
    else $error("more than one switch closed");
  a_osc_needs_switch: assert property (rc_osc_enable |-> sensor_channels != 16'h0)
    else $error("oscillator runs with all switches open");
  a_switch_close: assert property (
    acc && pwrite && paddr == SW && !pwdata[4] |-> ##2 sensor_channels == want)
    else $error("wrong switch closed");
  a_switch_open: assert property (
    acc && pwrite && paddr == SW && pwdata[4] |-> ##2 !rc_osc_enable && !(|sensor_channels))
    else $error("switches not all open");
  a_ctl_low_zero: assert property (acc && !pwrite && paddr == CT |-> prdata[2:0] == 3'h0)
    else $error("control low bits not zero");
  a_mode_gap_zero: assert property (acc && !pwrite && paddr == MD |-> prdata[3:2] == 2'h0)
    else $error("mode bits 2-3 not zero");
  a_switch_top_zero: assert property (acc && !pwrite && paddr == SW |-> prdata[7:5] == 3'h0)
    else $error("switch top bits not zero");
  a_irq_cleared: assert property (
    acc && !pwrite && paddr == ST && prdata[4] |-> ##2 !irq)
    else $error("interrupt stays after status read");
endmodule
bind rc_oscillation_converter rc_conv_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .rc_osc_enable(rc_osc_enable), .sensor_channels(sensor_channels), .irq(irq)
);

// ===== testbench/tb_top.sv
// self-checking bench for the rc converter over apb
// assumes the design, package, oscillator model and checker are compiled
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, slow, osc, osc_en, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] chan, seed;
  logic [7:0] a, b, c, d, e;
  int fails, tests_run, n;
  localparam logic [11:0] SW = {2'h0, rc_conv_pkg::IDX_SWITCH, 2'h0};
  localparam logic [11:0] CT = {2'h0, rc_conv_pkg::IDX_CONTROL, 2'h0};
  localparam logic [11:0] MD = {2'h0, rc_conv_pkg::IDX_MODE, 2'h0};
  localparam logic [11:0] RL = {2'h0, rc_conv_pkg::IDX_REF_LOW, 2'h0};
  localparam logic [11:0] RH = {2'h0, rc_conv_pkg::IDX_REF_HIGH, 2'h0};
  localparam logic [11:0] ML = {2'h0, rc_conv_pkg::IDX_MEAS_LOW, 2'h0};
  localparam logic [11:0] MH = {2'h0, rc_conv_pkg::IDX_MEAS_HIGH, 2'h0};
  localparam logic [11:0] ST = {2'h0, rc_conv_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] MK = {2'h0, rc_conv_pkg::IDX_IRQ_MASK, 2'h0};
  rc_oscillation_converter dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_in(osc), .rc_osc_enable(osc_en), .sensor_channels(chan), .irq(irq)
  );
  rc_osc_model u_osc (.enable(osc_en), .slow(slow), .osc(osc));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; data bits 31:16 random, 15:8 zero, since only [7:0] matter
  task automatic xfer(input logic [11:0] ad, input logic w, input logic [7:0] dt);
    int i;
    logic ok;
    seed = lf(seed);
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= {seed, 8'h00, dt};
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken while it stands, before the completing edge updates the slave
    for (i = 0; i < 20; i++) begin
      @(negedge pclk);
      ok = (pready === 1'b1);
      r = prdata;
      er = pslverr;
      @(posedge pclk);
      if (ok) break;
    end
    if (i == 20) begin fails++; wrap_up(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] ad, input logic [7:0] dt, input logic xe);
    xfer(ad, 1'b1, dt); chk({31'h0, er}, {31'h0, xe});
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] x, input logic xe);
    xfer(ad, 1'b0, 8'h00); chk(r, x); chk({31'h0, er}, {31'h0, xe});
  endtask
  task automatic run_wait();
    int i;
    for (i = 0; i < 300; i++) begin
      xfer(CT, 1'b0, 8'h00);
      if (r[4] === 1'b0) break;
    end
    if (i == 300) begin fails++; wrap_up(); end
    repeat (2) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; slow = 1'b0; seed = 16'h7CC6; fails = 0; tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(CT, 32'h08, 0); rd(MD, 0, 0); rd(SW, 32'h10, 0); rd(MK, 0, 0);
    rd(12'h000, 0, 1); rd(CT + 12'h001, 0, 1); rd(RH, 0, 1);
    wr(MD, 8'hFF, 0); rd(MD, 32'hF3, 0); wr(MD, 8'h02, 0);
    wr(CT, 8'h0F, 0); rd(CT, 32'h08, 0);
    for (n = 0; n < 17; n++) begin
      d = (n < 16) ? n[7:0] : {4'h1, seed[3:0]};
      wr(SW, {seed[7:5], d[4:0]}, 0); repeat (2) @(posedge pclk);
      chk({16'h0, chan}, (n < 16) ? 32'h1 << n : 32'h0);
      chk({31'h0, osc_en}, (n < 16) ? 32'h1 : 32'h0); rd(SW, {24'h0, d}, 0);
    end
    a = seed[7:0]; b = seed[15:8]; seed = lf(seed); c = seed[7:0]; d = seed[15:8];
    e = c ^ 8'h5A;
    wr(RL, a, 0); wr(RH, b, 0); wr(ML, c, 0); rd(RH, {24'h0, b}, 0);
    rd(RL, {24'h0, a}, 0); wr(RL, d, 0); wr(MH, e, 0); rd(RH, {24'h0, b}, 0);
    rd(ML, {24'h0, a}, 0); rd(MH, {24'h0, e}, 0); rd(ML, {24'h0, d}, 0);
    wr(MK, 8'h10, 0); wr(RL, 8'hF0, 0); wr(RH, 8'hFF, 0); wr(CT, 8'h10, 0);
    rd(RH, 0, 1); wr(RL, 8'h55, 1); run_wait(); chk({31'h0, irq}, 1);
    rd(ST, 32'h10, 0); @(negedge pclk); chk({31'h0, irq}, 0);
    @(posedge pclk); rd(ST, 0, 0);
    rd(RH, 0, 0); rd(RL, 0, 0); rd(MH, {24'h0, e}, 0); rd(ML, {24'h0, d}, 0);
    // divided reference outlasts 34 cycles; undivided would not
    wr(MD, 8'h03, 0); wr(RL, 8'hF0, 0); wr(RH, 8'hFF, 0); wr(CT, 8'h30, 0);
    repeat (30) @(posedge pclk);
    rd(CT, 32'h30, 0); run_wait(); chk({31'h0, irq}, 0); rd(ST, 0, 0);
    slow <= seed[0]; wr(SW, 8'h03, 0); wr(ML, 8'hFE, 0); wr(MH, 8'hFF, 0);
    wr(RL, 0, 0); wr(RH, 0, 0); wr(CT, 8'h10, 0); run_wait(); chk({31'h0, irq}, 1);
    wr(MK, 0, 0); repeat (2) @(posedge pclk); chk({31'h0, irq}, 0);
    wr(MK, 8'h10, 0); repeat (2) @(posedge pclk); chk({31'h0, irq}, 1);
    rd(ST, 32'h10, 0); rd(MH, 0, 0); rd(ML, 0, 0); rd(RH, 0, 0);
    wrap_up();
  end
endmodule
